// ===== xhl_decode.sv
// Purpose: decode and execute exclusive loads and immediate halfword loads
// Assumes: core supplies base register value; memory answers one access
//          with done plus fault flags; register file outside
// Notes:   one instruction in flight; issue_ready low while busy
// Notes on behaviour
// - exclusive word: address is base plus byte offset field times four.
// - shareable exclusive address is tagged in the global monitor.
// - every exclusive load that completes without fault arms the local monitor.
// - exclusive word with dest 13/15 or base 15 is unpredictable.
// - exclusive byte: base address, one-byte region, zero-extended result.
// - exclusive half: base address, two-byte region, zero-extended result.
// - stack pointer is accepted as base register.
// - halfword load zero-extends the fetched halfword to 32 bits.
// - halfword load supports offset, pre-indexed and post-indexed forms.
// - short form scales five-bit offset by two, offset mode only.
// - wide form uses twelve-bit offset unscaled; dest 13 unpredictable.
// - base field 1111 in 32-bit half forms means literal load, except wide form with dest 1111 (a hint).
// - listed dest 1111 encodings are unallocated memory hints.
// - index 1, add 1, write-back 0 is the unprivileged variant.
// - index 0 and write-back 0 is undefined.
// - index, add, write-back come from own bits; offset 0 to 255.
// - dest 13/15 or write-back with base equal dest unpredictable.
// - add set adds the offset, clear subtracts it.
// - access address is adjusted value if index, else plain base.
// - write-back stores the adjusted address into the base register.
// - memory hints execute as no-operations.
module xhl_decode
    import xhl_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // issue
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic cond_pass,
    input wire logic [31:0] base_value,
    output logic issue_ready,
    output logic [3:0] base_reg_field,
    // memory and monitors
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic [2:0] mem_size,
    output logic mon_local_set,
    output logic mon_global_set,
    output logic [31:0] mon_addr,
    output logic [2:0] mon_size,
    input wire logic mem_shareable,
    input wire logic mem_done,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_prot_err,
    input wire logic mem_bus_err,
    // register write-back
    output logic dest_we,
    output logic [3:0] dest_reg_field,
    output logic [31:0] dest_data,
    output logic base_we,
    output logic [3:0] base_wr_reg,
    output logic [31:0] base_wr_data,
    // exceptions and side decodes
    output logic undef_exc,
    output logic unpred_exc,
    output logic mem_protection_fault,
    output logic bus_error_fault,
    output logic literal_redirect,
    output logic unpriv_redirect
);
    // ==========================================================
    // decode
    logic [3:0] rn, rt;
    logic p_bit, u_bit, w_bit;
    logic is_exw, is_exb, is_exh, is_hw5, is_hw12, is_hw8;
    logic hint, lit, unpriv, undef, unpred;
    xhl_kind_t kind;
    logic [31:0] imm32;
    logic index, add, wback;
    logic [31:0] offset_addr, acc_addr;

    always_comb begin
        is_hw5 = instr[31:16] == 16'h0000 && instr[15:11] == XHL_HW5_OP;
        rn = is_hw5 ? {1'b0, instr[5:3]} : instr[19:16];
        rt = is_hw5 ? {1'b0, instr[2:0]} : instr[15:12];
        p_bit = instr[10];
        u_bit = instr[9];
        w_bit = instr[8];
        is_exw = instr[31:20] == XHL_EXW_OP;
        is_exb = instr[31:20] == XHL_EXBH_OP && instr[7:4] == XHL_EXB_SUB;
        is_exh = instr[31:20] == XHL_EXBH_OP && instr[7:4] == XHL_EXH_SUB;
        is_hw12 = instr[31:20] == XHL_HW12_OP;
        is_hw8 = instr[31:20] == XHL_HW8_OP && instr[11];
        // wide form: dest 1111 outranks base 1111, short 8-bit form the reverse
        lit = (is_hw12 && rn == XHL_REG_PC && rt != XHL_REG_PC) ||
            (is_hw8 && rn == XHL_REG_PC);
        hint = (is_hw12 && rt == XHL_REG_PC) || (is_hw8 && !lit &&
            rt == XHL_REG_PC && p_bit && !u_bit && !w_bit);
        unpriv = is_hw8 && !lit && !hint && p_bit && u_bit && !w_bit;
        undef = is_hw8 && !lit && !p_bit && !w_bit;
        // stack pointer is never rejected as a base here
        unpred = ((is_exw || is_exb || is_exh) &&
            (rt == XHL_REG_SP || rt == XHL_REG_PC || rn == XHL_REG_PC))
            || (is_hw12 && !lit && !hint && rt == XHL_REG_SP)
            || (is_hw8 && !lit && !hint && !unpriv && !undef &&
            (rt == XHL_REG_SP || rt == XHL_REG_PC || (w_bit && rn == rt)));
        kind = XHL_NONE;
        if (is_exw) kind = XHL_EXW;
        else if (is_exb) kind = XHL_EXB;
        else if (is_exh) kind = XHL_EXH;
        else if (is_hw5 || is_hw12 || is_hw8) kind = XHL_HW;
        index = 1'b1;
        add = 1'b1;
        wback = 1'b0;
        imm32 = 32'h0;
        if (is_exw) imm32 = {22'h0, instr[7:0], 2'b00};
        else if (is_hw5) imm32 = {26'h0, instr[10:6], 1'b0};
        else if (is_hw12) imm32 = {20'h0, instr[11:0]};
        else if (is_hw8) begin
            imm32 = {24'h0, instr[7:0]};
            index = p_bit;
            add = u_bit;
            wback = w_bit;
        end
        offset_addr = add ? base_value + imm32 : base_value - imm32;
        acc_addr = index ? offset_addr : base_value;
    end

    // ==========================================================
    // sequencer
    xhl_state_t state_q;
    logic go, go_mem;
    assign go = issue_valid && issue_ready;
    // condition failure and hints retire without effect
    assign go_mem = go && cond_pass && kind != XHL_NONE &&
        !hint && !lit && !unpriv && !undef && !unpred;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) state_q <= XHL_IDLE;
        else if (state_q == XHL_IDLE && go_mem) state_q <= XHL_WAIT;
        else if (state_q == XHL_WAIT && mem_done) state_q <= XHL_IDLE;
        else state_q <= state_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) issue_ready <= 1'b1;
        else issue_ready <= go_mem ? 1'b0 : (state_q == XHL_WAIT && mem_done)
            || (state_q == XHL_IDLE && issue_ready);
    end

    // ==========================================================
    // request and monitor arming
    logic is_ex_q, wback_q;
    logic [31:0] offset_q;
    xhl_kind_t kind_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= 1'b0;
            mem_addr <= 32'h0;
            mem_size <= 3'h0;
            mon_local_set <= 1'b0;
            mon_global_set <= 1'b0;
            mon_addr <= 32'h0;
            mon_size <= 3'h0;
            base_reg_field <= 4'h0;
            dest_reg_field <= 4'h0;
            is_ex_q <= 1'b0;
            wback_q <= 1'b0;
            offset_q <= 32'h0;
            kind_q <= XHL_NONE;
        end else begin
            mem_req <= go_mem;
            mon_local_set <= 1'b0;
            mon_global_set <= 1'b0;
            if (go_mem) begin
                kind_q <= kind;
                is_ex_q <= kind != XHL_HW;
                wback_q <= wback;
                offset_q <= offset_addr;
                base_reg_field <= rn;
                dest_reg_field <= rt;
                mem_addr <= acc_addr;
                mon_addr <= acc_addr;
                case (kind)
                    XHL_EXW: mem_size <= XHL_SIZE_W;
                    XHL_EXB: mem_size <= XHL_SIZE_B;
                    default: mem_size <= XHL_SIZE_H;
                endcase
                case (kind)
                    XHL_EXW: mon_size <= XHL_SIZE_W;
                    XHL_EXB: mon_size <= XHL_SIZE_B;
                    default: mon_size <= XHL_SIZE_H;
                endcase
            end
            // arm only once the access completes without fault
            if (state_q == XHL_WAIT && mem_done && is_ex_q &&
                !mem_prot_err && !mem_bus_err) begin
                mon_local_set <= 1'b1;
                mon_global_set <= mem_shareable;
            end
        end
    end

    // ==========================================================
    // completion and register writes
    logic fin;
    assign fin = state_q == XHL_WAIT && mem_done;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dest_we <= 1'b0;
            dest_data <= 32'h0;
            base_we <= 1'b0;
            base_wr_reg <= 4'h0;
            base_wr_data <= 32'h0;
            mem_protection_fault <= 1'b0;
            bus_error_fault <= 1'b0;
        end else begin
            dest_we <= fin && !mem_prot_err && !mem_bus_err;
            base_we <= fin && !mem_prot_err && !mem_bus_err && wback_q;
            mem_protection_fault <= fin && mem_prot_err;
            bus_error_fault <= fin && !mem_prot_err && mem_bus_err;
            if (fin) begin
                base_wr_reg <= base_reg_field;
                base_wr_data <= offset_q;
                case (kind_q)
                    XHL_EXW: dest_data <= mem_rdata;
                    XHL_EXB: dest_data <= {24'h0, mem_rdata[7:0]};
                    default: dest_data <= {16'h0, mem_rdata[15:0]};
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            undef_exc <= 1'b0;
            unpred_exc <= 1'b0;
            literal_redirect <= 1'b0;
            unpriv_redirect <= 1'b0;
        end else begin
            undef_exc <= go && cond_pass && undef;
            unpred_exc <= go && cond_pass && unpred;
            literal_redirect <= go && cond_pass && lit;
            unpriv_redirect <= go && cond_pass && unpriv;
        end
    end

    // ==========================================================
    // checks
    sequence s_ex_done;
        fin && is_ex_q && !mem_prot_err && !mem_bus_err;
    endsequence
    chk_local_arm: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ex_done |=> mon_local_set)
        else $error("local monitor not armed");
    chk_global_arm: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ex_done ##0 mem_shareable |=> mon_global_set)
        else $error("global monitor not armed");
    chk_no_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && !cond_pass |=> !mem_req)
        else $error("access on failed condition");
    chk_hint_nop: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && hint |=> !mem_req && !undef_exc && !unpred_exc)
        else $error("hint had effect");
    chk_fault_nowr: assert property (@(posedge core_clk) disable iff (!rst_n)
        fin && (mem_prot_err || mem_bus_err) |=> !dest_we && !base_we)
        else $error("write despite fault");
    chk_exw_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        go_mem && is_exw |=> mem_addr == $past(base_value)
            + {22'h0, $past(instr[7:0]), 2'b00})
        else $error("exclusive word address wrong");
    chk_post_idx: assert property (@(posedge core_clk) disable iff (!rst_n)
        go_mem && is_hw8 && !p_bit |=> mem_addr == $past(base_value))
        else $error("post-indexed address wrong");
    chk_undef: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && cond_pass && is_hw8 && !lit && !p_bit && !w_bit
            |=> undef_exc && !mem_req)
        else $error("undefined encoding not raised");
    chk_zero_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
        dest_we && kind_q == XHL_HW |-> dest_data[31:16] == 16'h0)
        else $error("halfword not zero-extended");
endmodule

// ===== xhl_pkg.sv
// Purpose: shared constants and types for the exclusive and halfword
//          load decoder
// Assumes: one core clock, instruction words arrive already aligned
// Notes:   16-bit forms sit in the low half of instr with instr[31:16] = 0
package xhl_pkg;
    // ==========================================================
    // instruction classes
    typedef enum logic [2:0] {
        XHL_NONE, XHL_EXW, XHL_EXB, XHL_EXH, XHL_HW
    } xhl_kind_t;

    typedef enum logic [1:0] {
        XHL_IDLE, XHL_WAIT
    } xhl_state_t;

    // ==========================================================
    // encodings, opcode and sub-op patterns and register numbers
    localparam logic [11:0] XHL_EXW_OP = 12'he85;
    localparam logic [11:0] XHL_EXBH_OP = 12'he8d;
    localparam logic [3:0] XHL_EXB_SUB = 4'h4;
    localparam logic [3:0] XHL_EXH_SUB = 4'h5;
    localparam logic [11:0] XHL_HW12_OP = 12'hf8b;
    localparam logic [11:0] XHL_HW8_OP = 12'hf83;
    localparam logic [4:0] XHL_HW5_OP = 5'h11;
    localparam logic [3:0] XHL_REG_PC = 4'hf;
    localparam logic [3:0] XHL_REG_SP = 4'hd;

    // ==========================================================
    // access sizes in bytes
    localparam logic [2:0] XHL_SIZE_B = 3'h1;
    localparam logic [2:0] XHL_SIZE_H = 3'h2;
    localparam logic [2:0] XHL_SIZE_W = 3'h4;
endpackage

// ===== xhl_mem_model.sv
// Purpose: behavioural memory system behind the load decoder
// Assumes: one access at a time, answered after lat_cycles
// Notes:   read data and shareable carry junk outside the answer cycle
module xhl_mem_model (
    // clock
    input wire logic core_clk,
    // access from the decoder
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    // knobs from the bench
    input wire logic [1:0] lat_cycles,
    input wire logic [31:0] fill_word,
    input wire logic inj_prot,
    input wire logic inj_bus,
    // answer
    output logic mem_done,
    output logic [31:0] mem_rdata,
    output logic mem_shareable,
    output logic mem_prot_err,
    output logic mem_bus_err
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mem_done = 1'b0;
        mem_rdata = 32'h0;
        mem_shareable = 1'b0;
        mem_prot_err = 1'b0;
        mem_bus_err = 1'b0;
        forever begin
            @(posedge core_clk);
            #1;
            if (mem_req === 1'b1) begin
                repeat (lat_cycles) begin
                    @(posedge core_clk);
                    #1;
                end
                mem_done = 1'b1;
                mem_rdata = fill_word;
                mem_shareable = mem_addr[4];
                mem_prot_err = inj_prot;
                mem_bus_err = inj_bus;
                @(posedge core_clk);
                #1;
                // released: inverted so stale data never matches
                mem_done = 1'b0;
                mem_rdata = ~fill_word;
                mem_shareable = ~mem_addr[4];
                mem_prot_err = 1'b0;
                mem_bus_err = 1'b0;
            end
        end
    end
endmodule

// ===== tb_exclusive_and_halfword_load_decode.sv
// Purpose: random self-checking bench for the load decoder
// Assumes: inputs change 1 ns after the rising edge
// Notes:   cond fail is drawn for every kind of instruction
module tb_exclusive_and_halfword_load_decode
    import xhl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, rst_n, issue_valid, cond_pass, issue_ready, mem_req;
    logic [31:0] instr, base_value, mem_addr, mon_addr, dest_data;
    logic [31:0] base_wr_data, mem_rdata, fill_word, e_addr, e_wbval;
    logic [3:0] base_reg_field, dest_reg_field, base_wr_reg, e_dest, e_base;
    logic [2:0] mem_size, mon_size, e_size;
    logic [1:0] lat_cycles;
    logic mon_local_set, mon_global_set, mem_shareable, mem_done, ok;
    logic mem_prot_err, mem_bus_err, dest_we, base_we, undef_exc;
    logic unpred_exc, mem_protection_fault, bus_error_fault;
    logic literal_redirect, unpriv_redirect, inj_prot, inj_bus, e_wb, e_excl;
    int num_errors, total_checks, e_code;

    xhl_decode i_dut (.core_clk, .rst_n, .issue_valid, .instr, .cond_pass,
        .base_value, .issue_ready, .base_reg_field, .mem_req, .mem_addr,
        .mem_size, .mon_local_set, .mon_global_set, .mon_addr, .mon_size,
        .mem_shareable, .mem_done, .mem_rdata, .mem_prot_err, .mem_bus_err,
        .dest_we, .dest_reg_field, .dest_data, .base_we, .base_wr_reg,
        .base_wr_data, .undef_exc, .unpred_exc, .mem_protection_fault,
        .bus_error_fault, .literal_redirect, .unpriv_redirect);
    xhl_mem_model i_mem (.core_clk, .mem_req, .mem_addr, .lat_cycles,
        .fill_word, .inj_prot, .inj_bus, .mem_done, .mem_rdata,
        .mem_shareable, .mem_prot_err, .mem_bus_err);

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    // ====================
    // checking and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ====================
    // reference model: code 0 none, 1 undef, 2 unpred, 3 lit, 4 unpriv,
    // 5 memory access
    task automatic predict(input logic [31:0] w, input logic [31:0] b);
        logic [3:0] n;
        logic [3:0] t;
        n = w[19:16];
        t = w[15:12];
        e_wbval = w[9] ? b + w[7:0] : b - w[7:0];
        {e_wb, e_excl, e_size, e_addr} = {2'b0, XHL_SIZE_H, b};
        e_code = 5;
        if (w[31:16] == 16'h0) begin
            n = {1'b0, w[5:3]};
            t = {1'b0, w[2:0]};
            e_addr = b + {w[10:6], 1'b0};
        end else if (w[31:20] == XHL_EXW_OP) begin
            {e_excl, e_size} = {1'b1, XHL_SIZE_W};
            e_addr = b + {w[7:0], 2'b00};
            if (t == 13 || t == 15 || n == 15) e_code = 2;
        end else if (w[31:20] == XHL_EXBH_OP) begin
            e_excl = 1'b1;
            e_size = w[4] ? XHL_SIZE_H : XHL_SIZE_B;
            if (t == 13 || t == 15 || n == 15) e_code = 2;
        end else if (w[31:20] == XHL_HW12_OP) begin
            e_addr = b + w[11:0];
            if (t == 15) e_code = 0;
            else if (n == 15) e_code = 3;
            else if (t == 13) e_code = 2;
        end else begin
            e_wb = w[8];
            if (w[10]) e_addr = e_wbval;
            if (n == 15) e_code = 3;
            else if (t == 15 && w[10:8] == 3'b100) e_code = 0;
            else if (w[10:8] == 3'b110) e_code = 4;
            else if (!w[10] && !w[8]) e_code = 1;
            else if (t == 13 || t == 15 || (w[8] && n == t)) e_code = 2;
        end
        {e_dest, e_base} = {t, n};
    endtask

    function automatic logic [31:0] gen(input int k);
        logic [31:0] r;
        r = $urandom;
        if ($urandom % 4 == 0) r[11:0] = 12'hfff;
        case (k)
            0: r = {16'h0, XHL_HW5_OP, r[10:0]};
            1: r = {XHL_EXW_OP, r[19:12], 4'hf, r[7:0]};
            2: r = {XHL_EXBH_OP, r[19:12], 7'h7a, r[4], 4'hf};
            3: r = {XHL_HW12_OP, r[19:0]};
            default: r = {XHL_HW8_OP, r[19:12], 1'b1, r[10:0]};
        endcase
        return r;
    endfunction

    // ====================
    // one instruction, issue to completion
    task automatic run_op(input int k);
        @(posedge core_clk);
        #1;
        instr = gen(k);
        base_value = $urandom;
        predict(instr, base_value);
        cond_pass = ($urandom % 6 != 0);
        lat_cycles = 2'($urandom % 4);
        fill_word = $urandom;
        inj_prot = ($urandom % 8 == 0);
        inj_bus = ($urandom % 8 == 0);
        issue_valid = 1'b1;
        @(posedge core_clk);
        #1;
        issue_valid = 1'b0;
        if (!cond_pass) e_code = 0;
        chk(undef_exc, e_code == 1);
        chk(unpred_exc, e_code == 2);
        chk(literal_redirect, e_code == 3);
        chk(unpriv_redirect, e_code == 4);
        chk(mem_req, e_code == 5);
        chk(issue_ready, e_code != 5);
        if (e_code == 5) begin
            chk(mem_addr, e_addr);
            chk(mem_size, e_size);
            chk(base_reg_field, e_base);
            for (int i = 0; i < 30 && (dest_we | mem_protection_fault
                    | bus_error_fault) !== 1'b1; i++) begin
                @(posedge core_clk);
                #1;
            end
            ok = !(inj_prot | inj_bus);
            chk(mem_protection_fault, inj_prot);
            chk(bus_error_fault, inj_bus & !inj_prot);
            chk(dest_we, ok);
            chk(issue_ready, 1'b1);
            chk(base_we, ok & e_wb);
            chk(mon_local_set, ok & e_excl);
            chk(mon_global_set, ok & e_excl & e_addr[4]);
            if (ok) begin
                chk(dest_reg_field, e_dest);
                chk(dest_data, e_size == XHL_SIZE_W ? fill_word :
                    e_size == XHL_SIZE_B ? {24'h0, fill_word[7:0]} :
                    {16'h0, fill_word[15:0]});
                if (e_wb) chk(base_wr_reg, e_base);
                if (e_wb) chk(base_wr_data, e_wbval);
                if (e_excl) chk(mon_addr, e_addr);
                if (e_excl) chk(mon_size, e_size);
            end
        end else begin
            chk(dest_we, 1'b0);
        end
    endtask

    // ====================
    // main sequence and watchdog
    initial begin
        {rst_n, issue_valid, cond_pass, inj_prot, inj_bus} = 5'h0;
        {instr, base_value, fill_word, lat_cycles} = 98'h0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(7991));
        repeat (2) @(posedge core_clk);
        #1;
        chk(issue_ready, 1'b1);
        chk(mem_req, 1'b0);
        rst_n = 1'b1;
        for (int i = 0; i < 500; i++) run_op(i % 5);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        test_done();
    end
endmodule
